// file: utx_pkg.sv
// utx_pkg: constants, register map and types for the uart transmit path
// assumes a 32-bit apb register bus and a single 50 mhz clock
package utx_pkg;
   localparam int unsigned NUM_CHANNELS = 8;
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned FIFO_DEPTH = 64;
   localparam int unsigned FIFO_AW = 6;
   localparam int unsigned CH_STRIDE = 'h10;
   // per-channel register byte offsets inside the channel stride
   localparam logic [3:0] OFS_TX_HOLDING = 4'h0;
   localparam logic [3:0] OFS_DIVISOR_LOW = 4'h4;
   localparam logic [3:0] OFS_DIVISOR_HIGH = 4'h8;
   localparam logic [3:0] OFS_CONTROL = 4'hc;
   // global registers above the channel block
   localparam logic [11:0] ADDR_BROADCAST = 12'h100;
   localparam logic [11:0] ADDR_STATUS_BASE = 12'h200;
   // control register fields
   localparam int unsigned CTL_FIFO_EN = 0;
   localparam int unsigned CTL_RS485 = 1;
   localparam int unsigned CTL_PRESCALE4 = 2;
   localparam int unsigned CTL_EIGHT_X = 3;
   localparam int unsigned CTL_TX_IRQ_EN = 4;
   localparam int unsigned CTL_PARITY_EN = 5;
   localparam int unsigned CTL_PARITY_EVEN = 6;
   localparam int unsigned CTL_TWO_STOP = 7;
   localparam int unsigned CTL_WLEN_LO = 8;
   localparam int unsigned CTL_TRIG_LO = 10;
   // status register fields
   localparam int unsigned ST_HOLD_EMPTY = 5;
   localparam int unsigned ST_TX_EMPTY = 6;
   localparam int unsigned ST_TX_INT = 7;
   localparam int unsigned ST_LEVEL_LO = 8;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [15:0] DIVISOR_RESET = 16'h0001;
   localparam logic [3:0] SAMPLES_16X = 4'hf;
   localparam logic [3:0] SAMPLES_8X = 4'h7;
   localparam logic [1:0] PRESCALE4_LAST = 2'h3;
   typedef enum logic [4:0] {
      UTX_IDLE = 5'b00001,
      UTX_START = 5'b00010,
      UTX_DATA = 5'b00100,
      UTX_PARITY = 5'b01000,
      UTX_STOP = 5'b10000
   } utx_state_t;
endpackage

// file: utx_channel.sv
// utx_channel: one transmit channel with rate generator, fifo and shifter
// assumes register writes arrive as one-cycle pulses from the bus slave
`timescale 1ns/10ps
`default_nettype none
module utx_channel
   import utx_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic pclk, // shared clock
   input wire logic presetn, // async reset, low
   input wire logic [15:0] control, // channel control word
   input wire logic [15:0] divisor, // rate divisor
   input wire logic wr_data, // holding register write pulse
   input wire logic [7:0] wdata, // byte to send
   output logic serial_out, // serial tx line
   output logic [7:0] status, // line status bits
   output logic [6:0] level, // fifo fill level
   output logic tx_int // transmitter interrupt level
);
   typedef struct packed {
      logic [1:0] pre;
      logic [15:0] div_cnt;
      logic [3:0] samp;
      logic [2:0] bitn;
      logic [7:0] sh;
      logic par;
      logic stop2;
      logic tx;
      utx_state_t st;
      logic [FIFO_AW-1:0] rp;
      logic [FIFO_AW-1:0] wp;
      logic [6:0] cnt;
      logic hold_empty;
   } utx_ch_t;
   utx_ch_t q, d;
   logic [7:0] mem [DEPTH];
   logic tick, pre_tick, bit_end, pop, push, trig_above;
   logic [2:0] last_bit;
   logic [6:0] trig;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      trig = 7'h01;
      case (control[CTL_TRIG_LO +: 2])
         2'h0: trig = 7'h01;
         2'h1: trig = 7'h08;
         2'h2: trig = 7'h10;
         default: trig = 7'h20;
      endcase
      last_bit = 3'h4 + {1'b0, control[CTL_WLEN_LO +: 2]};
      pre_tick = !control[CTL_PRESCALE4] || q.pre == PRESCALE4_LAST;
      tick = pre_tick && q.div_cnt <= 16'h0001;
      bit_end = tick && q.samp == 4'h0;
      push = wr_data && (q.cnt < 7'(DEPTH));
      pop = 1'b0;
      d = q;
      d.pre = control[CTL_PRESCALE4] ? q.pre + 2'h1 : 2'h0;
      if (pre_tick) begin
         d.div_cnt = (q.div_cnt <= 16'h0001) ? divisor : q.div_cnt - 16'h0001;
      end
      if (tick) begin
         d.samp = (q.samp == 4'h0) ?
            (control[CTL_EIGHT_X] ? SAMPLES_8X : SAMPLES_16X) : q.samp - 4'h1;
      end
      case (q.st)
         UTX_IDLE: begin
            d.tx = 1'b1;
            if (q.cnt != 7'h0 && bit_end) begin
               pop = 1'b1;
               d.sh = mem[q.rp];
               d.par = !control[CTL_PARITY_EVEN];
               d.bitn = 3'h0;
               d.tx = 1'b0;
               d.st = UTX_START;
            end
         end
         UTX_START: if (bit_end) begin
            d.tx = q.sh[0];
            d.par = q.par ^ q.sh[0];
            d.sh = {1'b0, q.sh[7:1]};
            d.st = UTX_DATA;
         end
         UTX_DATA: if (bit_end) begin
            if (q.bitn == last_bit) begin
               d.tx = control[CTL_PARITY_EN] ? q.par : 1'b1;
               d.stop2 = control[CTL_TWO_STOP];
               d.st = control[CTL_PARITY_EN] ? UTX_PARITY : UTX_STOP;
            end else begin
               d.tx = q.sh[0];
               d.par = q.par ^ q.sh[0];
               d.sh = {1'b0, q.sh[7:1]};
               d.bitn = q.bitn + 3'h1;
            end
         end
         UTX_PARITY: if (bit_end) begin
            d.tx = 1'b1;
            d.st = UTX_STOP;
         end
         UTX_STOP: if (bit_end) begin
            if (q.stop2) begin
               d.stop2 = 1'b0;
            end else begin
               d.st = UTX_IDLE;
            end
         end
         default: d.st = UTX_IDLE;
      endcase
      if (push) begin
         d.wp = q.wp + FIFO_AW'(1);
      end
      if (pop) begin
         d.rp = q.rp + FIFO_AW'(1);
      end
      d.cnt = q.cnt + {6'h0, push} - {6'h0, pop};
      // non-fifo: flag sets on hand-over to the shifter, clears on write
      if (pop) begin
         d.hold_empty = 1'b1;
      end else if (push) begin
         d.hold_empty = 1'b0;
      end
      if (control[CTL_FIFO_EN]) begin
         d.hold_empty = (d.cnt == 7'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk) begin
      if (push) begin
         mem[q.wp] <= wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{pre: 2'h0, div_cnt: 16'h0001, samp: 4'h0, bitn: 3'h0, sh: 8'h0,
            par: 1'b0, stop2: 1'b0, tx: 1'b1, st: UTX_IDLE, rp: '0, wp: '0,
            cnt: 7'h0, hold_empty: 1'b1};
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic tx_idle;
   assign tx_idle = q.st == UTX_IDLE && q.cnt == 7'h0;
   assign trig_above = q.cnt > trig;
   assign serial_out = q.tx;
   assign level = q.cnt;
   always_comb begin
      status = 8'h0;
      status[ST_HOLD_EMPTY] = q.hold_empty;
      status[ST_TX_EMPTY] = tx_idle;
      if (!control[CTL_FIFO_EN]) begin
         tx_int = control[CTL_TX_IRQ_EN] && q.hold_empty;
      end else if (control[CTL_RS485]) begin
         tx_int = trig_above && !tx_idle;
      end else begin
         tx_int = trig_above && q.cnt != 7'h0;
      end
      status[ST_TX_INT] = tx_int;
   end
endmodule
`default_nettype wire

// file: utx_top.sv
// utx_top: eight uart transmit channels behind an apb slave
// Contract
// - fifo mode: tx pin high above trigger
// - fifo rs485 mode: low below trigger or idle
// - fifo mode: rx pin high below rx trigger
// - one clock feeds all eight channels
// - one rate generator per channel
// - prescaler divides by four or one
// - sixteen-bit divisor, one to 65535
// - divisor built from high and low bytes
// - eight-x select halves samples per bit
// - eight-bit shifter fed by 64-byte fifo
// - each bit lasts sixteen samples, eight with eight-x
// - start, data, parity, stop order
// - data sent least significant bit first
// - each write below full stores byte, advances pointer
// - non-fifo mode: holding-empty sets on shifter load
// - non-fifo tx interrupt only when enabled
// - tx-empty only when shifter idle
// - fifo mode: holding-empty means fifo empty
// - broadcast writes reach all channels
// assumes an apb master on pclk; receive fifo levels come in as inputs
`timescale 1ns/10ps
`default_nettype none
module utx_top
   import utx_pkg::*;
#(
   parameter int CHANNELS = NUM_CHANNELS
) (
   input wire logic pclk, // apb and baud clock
   input wire logic presetn, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic [CHANNELS-1:0] rx_above_trig, // rx fifo above trigger
   output logic [CHANNELS-1:0] serial_out, // serial tx lines
   output logic [CHANNELS-1:0] tx_int, // tx interrupt levels
   output logic [CHANNELS-1:0] rx_int // rx interrupt levels
);
   typedef struct packed {
      logic [CHANNELS-1:0][15:0] ctl;
      logic [CHANNELS-1:0][15:0] div;
      logic bcast;
      logic [31:0] rdata;
      logic err;
   } utx_top_t;
   utx_top_t q, d;
   logic [CHANNELS-1:0] wr_thr;
   logic [CHANNELS-1:0][7:0] st;
   logic [CHANNELS-1:0][6:0] lvl;
   logic access, setup, wr, rd;
   logic [2:0] sel_ch;
   logic in_ch;

   function automatic logic ch_hit(input logic [2:0] ch, input logic [2:0] sel,
                                   input logic bc);
      return bc || ch == sel;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   assign access = psel && penable;
   assign setup = psel && !penable;
   assign wr = access && pwrite;
   // read data and error are prepared in setup so they stand in the access cycle
   assign rd = setup && !pwrite;
   assign sel_ch = paddr[6:4];
   assign in_ch = paddr[11:7] == 5'h0 && paddr[1:0] == 2'h0;
   assign pready = 1'b1;
   assign prdata = q.rdata;
   assign pslverr = q.err;

   always_comb begin
      d = q;
      d.err = 1'b0;
      wr_thr = '0;
      for (int i = 0; i < CHANNELS; i++) begin
         if (wr && in_ch && ch_hit(3'(i), sel_ch, q.bcast)) begin
            case (paddr[3:0])
               OFS_TX_HOLDING: wr_thr[i] = 1'b1;
               OFS_DIVISOR_LOW: d.div[i][7:0] = pwdata[7:0];
               OFS_DIVISOR_HIGH: d.div[i][15:8] = pwdata[7:0];
               OFS_CONTROL: d.ctl[i] = pwdata[15:0];
               default: ;
            endcase
         end
      end
      if (wr && paddr == ADDR_BROADCAST) begin
         d.bcast = pwdata[0];
      end
      if (rd) begin
         d.rdata = 32'h0;
         if (in_ch) begin
            case (paddr[3:0])
               OFS_DIVISOR_LOW: d.rdata = {24'h0, q.div[sel_ch][7:0]};
               OFS_DIVISOR_HIGH: d.rdata = {24'h0, q.div[sel_ch][15:8]};
               OFS_CONTROL: d.rdata = {16'h0, q.ctl[sel_ch]};
               default: d.rdata = 32'h0; // holding register is write-only
            endcase
         end else if (paddr == ADDR_BROADCAST) begin
            d.rdata = {31'h0, q.bcast};
         end else if (paddr[11:5] == ADDR_STATUS_BASE[11:5] && paddr[1:0] == 2'h0) begin
            d.rdata = {17'h0, lvl[paddr[4:2]], st[paddr[4:2]]};
         end else begin
            d.err = 1'b1;
         end
      end else if (setup && pwrite && !in_ch && paddr != ADDR_BROADCAST) begin
         d.err = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.ctl <= '{default: CTL_RESET};
         q.div <= '{default: DIVISOR_RESET};
         q.bcast <= 1'b0;
         q.rdata <= 32'h0;
         q.err <= 1'b0;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
      utx_channel u_ch (
         .pclk(pclk),
         .presetn(presetn),
         .control(q.ctl[g]),
         .divisor(q.div[g]),
         .wr_data(wr_thr[g]),
         .wdata(pwdata[7:0]),
         .serial_out(serial_out[g]),
         .status(st[g]),
         .level(lvl[g]),
         .tx_int(tx_int[g])
      );
      assign rx_int[g] = q.ctl[g][CTL_FIFO_EN] && !rx_above_trig[g];
   end
endmodule
`default_nettype wire

// file: utx_checker.sv
// utx_checker: port assertions for the uart transmit path
// assumes it is bound onto utx_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module utx_checker #(
   parameter int CHANNELS = 8
) (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic [CHANNELS-1:0] rx_above_trig, // rx levels
   input wire logic [CHANNELS-1:0] serial_out, // tx lines
   input wire logic [CHANNELS-1:0] tx_int, // tx interrupts
   input wire logic [CHANNELS-1:0] rx_int // rx interrupts
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////
   a_idle_after_reset: assert property ($rose(presetn) |-> &serial_out)
      else $error("line not idle after reset");
   a_quiet_after_reset: assert property ($rose(presetn) |-> tx_int == '0)
      else $error("tx interrupt after reset");
   a_low_bit_len: assert property ($fell(serial_out[0]) |-> !serial_out[0] [*8])
      else $error("low bit too short");
   a_high_bit_len: assert property ($rose(serial_out[0]) |-> serial_out[0] [*8])
      else $error("high bit too short");
   a_rx_int_low: assert property (rx_above_trig[0] |-> !rx_int[0])
      else $error("rx interrupt above trigger");
   a_zero_wait: assert property (psel && penable |-> pready)
      else $error("ready missing");
   a_holding_reads_zero: assert property (
      psel && penable && !pwrite && paddr == 12'h000 |-> prdata == 32'h0)
      else $error("holding register readable");
   a_holding_write_ok: assert property (
      psel && penable && pwrite && paddr == 12'h000 |-> !pslverr)
      else $error("holding write refused");
   cover property ($fell(serial_out[0]));
   cover property (tx_int[3]);
   cover property (pslverr);
endmodule
bind utx_top utx_checker #(.CHANNELS(CHANNELS)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_above_trig(rx_above_trig),
   .serial_out(serial_out), .tx_int(tx_int), .rx_int(rx_int));
`default_nettype wire

// file: utx_far_rx.sv
// utx_far_rx: remote serial receiver sampling one tx line mid-bit
// assumes the bench sets bit_cycles before each frame
`timescale 1ns/10ps
`default_nettype none
module utx_far_rx (
   input wire logic pclk, // clock
   input wire logic line, // watched serial line
   input wire logic [15:0] bit_cycles, // clocks per bit
   output logic [10:0] frame, // sampled bits, start at bit 0
   output logic [15:0] start_len, // start bit length in clocks
   output logic [7:0] n_frames // frames seen
);
   int cnt;
   ////////////////////////////////////////////////////////////////
   initial begin
      frame = '0;
      start_len = '0;
      n_frames = '0;
      forever begin
         @(negedge pclk);
         if (line === 1'b0) begin
            cnt = 0;
            while (line === 1'b0 && cnt < 70000) begin
               @(negedge pclk);
               cnt++;
            end
            start_len = cnt[15:0];
            frame[0] = 1'b0;
            repeat (bit_cycles / 2) @(negedge pclk);
            for (int i = 1; i < 11; i++) begin
               frame[i] = line;
               repeat (bit_cycles) @(negedge pclk);
            end
            n_frames++;
         end
      end
   end
endmodule
`default_nettype wire

// file: test_uart_tx_baud_irq_path.sv
// test_uart_tx_baud_irq_path: apb driven bench for the transmit path
// assumes utx_top, utx_far_rx on channel 0 and the bound checker
`timescale 1ns/10ps
`default_nettype none
module test_uart_tx_baud_irq_path;
   import utx_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] rx_above_trig, serial_out, tx_int, rx_int, n_frames;
   logic [15:0] bit_cycles, start_len;
   logic [10:0] frame;
   int n_errors, compares;
   utx_top #(.CHANNELS(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_above_trig(rx_above_trig),
      .serial_out(serial_out), .tx_int(tx_int), .rx_int(rx_int));
   utx_far_rx u_far (.pclk(pclk), .line(serial_out[0]), .bit_cycles(bit_cycles),
      .frame(frame), .start_len(start_len), .n_frames(n_frames));
   ////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      // read data and error are taken at the completing edge
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic send(input logic [15:0] ctl, input logic [7:0] dv);
      logic [7:0] n0;
      logic p;
      p = ctl[CTL_PARITY_EN] ? (ctl[CTL_PARITY_EVEN] ? ^8'ha5 : ~^8'ha5) : 1'b1;
      bit_cycles = 16'(dv * (ctl[CTL_PRESCALE4] ? 4 : 1) * (ctl[CTL_EIGHT_X] ? 8 : 16));
      apb(1'b1, 12'h00c, {16'h0, ctl});
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b1, 12'h004, {24'h0, dv});
      n0 = n_frames;
      apb(1'b1, 12'h000, 32'ha5);
      // the old divisor count runs out before the new rate takes over
      for (int k = 0; k < 3000 && serial_out[0] !== 1'b0; k++) @(posedge pclk);
      repeat (3 * bit_cycles) @(posedge pclk);
      apb(1'b0, 12'h200, 32'h0);
      check("mid flags", rd[6:5], 2'b01);
      for (int k = 0; k < 3000 && n_frames == n0; k++) @(posedge pclk);
      check("frame count", n_frames, n0 + 8'h01);
      check("frame", frame, {1'b1, p, 8'ha5, 1'b0});
      check("bit time", start_len, bit_cycles);
      repeat (2 * bit_cycles) @(posedge pclk);
      apb(1'b0, 12'h200, 32'h0);
      check("end flags", rd[6:5], 2'b11);
      check("line idle", serial_out[0], 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      repeat (60000) @(posedge pclk);
      n_errors++;
      test_done;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, rx_above_trig} = '0;
      bit_cycles = 16'h0010;
      n_errors = 0;
      compares = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADDR_STATUS_BASE, 32'h0);
      check("reset status", rd[14:5], 10'h003);
      check("reset lines", serial_out, 8'hff);
      apb(1'b0, 12'h300, 32'h0);
      check("unmapped error", err, 1'b1);
      apb(1'b1, 12'h008, 32'h09);
      apb(1'b1, 12'h004, 32'h00);
      apb(1'b0, 12'h008, 32'h0);
      check("divisor high", rd, 32'h09);
      apb(1'b0, 12'h004, 32'h0);
      check("divisor low", rd, 32'h00);
      apb(1'b0, 12'h000, 32'h0);
      check("holding read", rd, 32'h0);
      send(16'h0360, 8'h02);
      send(16'h0308, 8'h02);
      send(16'h0304, 8'h01);
      send(16'h03a0, 8'h01);
      apb(1'b1, ADDR_BROADCAST, 32'h1);
      apb(1'b1, 12'h00c, 32'h0701);
      apb(1'b1, ADDR_BROADCAST, 32'h0);
      apb(1'b0, 12'h05c, 32'h0);
      check("broadcast control", rd, 32'h0701);
      rx_above_trig <= 8'h0f;
      repeat (2) @(posedge pclk);
      check("rx interrupts", rx_int, 8'hf0);
      apb(1'b1, 12'h038, 32'h09);
      for (int i = 0; i < 10; i++) apb(1'b1, 12'h030, i);
      apb(1'b0, 12'h20c, 32'h0);
      check("fifo holding empty", rd[ST_HOLD_EMPTY], 1'b0);
      check("tx above trigger", tx_int[3], 1'b1);
      check("tx fifo empty", tx_int[4], 1'b0);
      apb(1'b1, 12'h03c, 32'h0b03);
      check("rs485 below trigger", tx_int[3], 1'b0);
      apb(1'b1, 12'h03c, 32'h0703);
      check("rs485 above trigger", tx_int[3], 1'b1);
      apb(1'b1, 12'h05c, 32'h0010);
      check("holding empty irq", tx_int[5], 1'b1);
      test_done;
   end
endmodule
`default_nettype wire
